// ===== tcp_fsm.sv
// Two-cell protection control: delay qualification and gate control
// Assumes comparator levels arrive asynchronously and are synchronised here
//
// Notes on behaviour
// - Either cell overcharged for the detect delay drives charge gate low.
// - In overcharge, over-current detection is off, short-circuit stays active.
// - Both cells below release level restore charge gate after release delay.
// - Load node high with no load keeps charge gate low even with both cells below release level.
// - After overcharge release, excessive charger evaluation begins and can hold gate low.
// - Either cell overdischarged for the detect delay drives discharge gate low.
// - Confirmed overdischarge enters standby with monitoring stopped.
// - Confirmed overdischarge enables the pull-up resistor on charger-negative node.
// - Standby ends only when standby-release comparator fires; monitoring resumes.
// - After standby, both cells above level restore discharge gate after delay.
// - Over-current held for its delay drives discharge gate low.
// - Short-circuit drives discharge gate low after a shorter delay.
// - Confirmed over-current or short enables pull-down resistor on charger-negative node.
// - Over-current or short does not enter standby.
// - Excessive charger must persist 1.5 ms before charge gate goes low.
// - Excessive charger clearing restores charge gate after 1.5 ms.
// - Excessive charger count is held off during overdischarge.
// - Test input high shortens counter delays; board ties it low normally.
// - Overcharge detect 1.0 s, release 40.0 ms.
// - Overdischarge detect 100 ms, release 1.0 ms.
// - Over-current detect delay 20.0 ms.
// - Short-circuit delay 0.250 ms, not shortened by test input.
`timescale 1ns/1ps
`include "tcp_defs.svh"

module tcp_fsm (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Comparator inputs, asynchronous
  input  wire logic overcharge_det,
  input  wire logic overcharge_rel_ok,
  input  wire logic overdischarge_det,
  input  wire logic overdischarge_rel_ok,
  input  wire logic load_node_above_oc,
  input  wire logic load_present,
  input  wire logic short_det,
  input  wire logic excess_charger_det,
  input  wire logic standby_release,
  input  wire logic test_shorten,
  // Gate and resistor controls
  output logic      charge_gate,
  output logic      discharge_gate,
  output logic      pullup_resistor_enable,
  output logic      pulldown_resistor_enable,
  output logic      standby
);
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int NIN = 10;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  assign raw = {test_shorten, standby_release, excess_charger_det, short_det,
                load_present, load_node_above_oc, overdischarge_rel_ok,
                overdischarge_det, overcharge_rel_ok, overcharge_det};

  // Two flops per input
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate

  logic oc_det, oc_rel, od_det, od_rel, node_hi, load_on, sc_det, xc_det, stb_rel, tst;
  assign {tst, stb_rel, xc_det, sc_det, load_on, node_hi, od_rel, od_det, oc_rel, oc_det} = s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Delay limits, shortened in test mode except short-circuit
  function automatic tcp_pkg::tcp_cnt_t lim(input longint cyc, input logic t);
    longint v;
    v = t ? cyc / `TCP_TEST_DIV : cyc;
    if (v < 1) v = 1;
    return tcp_pkg::tcp_cnt_t'(v);
  endfunction

  tcp_pkg::tcp_cnt_t l_ocd, l_ocr, l_odd, l_odr, l_oid, l_oir, l_scd, l_xcd, l_xcr;
  assign l_ocd = lim(`TCP_US2CYC(64'd`TCP_OC_DET_US), tst);
  assign l_ocr = lim(`TCP_US2CYC(64'd`TCP_OC_REL_US), tst);
  assign l_odd = lim(`TCP_US2CYC(64'd`TCP_OD_DET_US), tst);
  assign l_odr = lim(`TCP_US2CYC(64'd`TCP_OD_REL_US), tst);
  assign l_oid = lim(`TCP_US2CYC(64'd`TCP_OI_DET_US), tst);
  assign l_oir = lim(`TCP_US2CYC(64'd`TCP_OI_REL_US), tst);
  assign l_scd = lim(`TCP_US2CYC(64'd`TCP_SC_DET_US), 1'b0);
  assign l_xcd = lim(`TCP_US2CYC(64'd`TCP_XC_DET_US), tst);
  assign l_xcr = lim(`TCP_US2CYC(64'd`TCP_XC_REL_US), tst);

  ////////////////////////////////////////////////////////////////////////////
  // State flags
  logic oc_q, oc_d;     // Overcharge held
  logic od_q, od_d;     // Overdischarge held
  logic stb_q, stb_d;   // Standby
  logic oi_q, oi_d;     // Over-current or short held
  logic xc_q, xc_d;     // Excessive charger held

  // Qualifying conditions
  logic c_ocd, c_ocr, c_odd, c_odr, c_oid, c_oir, c_scd, c_xcd, c_xcr;
  logic d_ocd, d_ocr, d_odd, d_odr, d_oid, d_oir, d_scd, d_xcd, d_xcr;

  always_comb begin
    c_ocd = !oc_q && oc_det && !stb_q;
    c_ocr = oc_q && oc_rel && (!node_hi || load_on);
    c_odd = !od_q && od_det && !stb_q;
    c_odr = od_q && !stb_q && od_rel;
    c_oid = !oi_q && !oc_q && !od_q && node_hi;
    c_oir = oi_q && !node_hi;
    c_scd = !oi_q && !od_q && sc_det;
    c_xcd = !xc_q && !oc_q && !od_q && xc_det;
    c_xcr = xc_q && !xc_det;
  end

  // One timer per condition
  tcp_delay u_ocd (.clock(clock), .rst_n(rst_n), .cond(c_ocd), .limit(l_ocd), .done(d_ocd));
  tcp_delay u_ocr (.clock(clock), .rst_n(rst_n), .cond(c_ocr), .limit(l_ocr), .done(d_ocr));
  tcp_delay u_odd (.clock(clock), .rst_n(rst_n), .cond(c_odd), .limit(l_odd), .done(d_odd));
  tcp_delay u_odr (.clock(clock), .rst_n(rst_n), .cond(c_odr), .limit(l_odr), .done(d_odr));
  tcp_delay u_oid (.clock(clock), .rst_n(rst_n), .cond(c_oid), .limit(l_oid), .done(d_oid));
  tcp_delay u_oir (.clock(clock), .rst_n(rst_n), .cond(c_oir), .limit(l_oir), .done(d_oir));
  tcp_delay u_scd (.clock(clock), .rst_n(rst_n), .cond(c_scd), .limit(l_scd), .done(d_scd));
  tcp_delay u_xcd (.clock(clock), .rst_n(rst_n), .cond(c_xcd), .limit(l_xcd), .done(d_xcd));
  tcp_delay u_xcr (.clock(clock), .rst_n(rst_n), .cond(c_xcr), .limit(l_xcr), .done(d_xcr));

  ////////////////////////////////////////////////////////////////////////////
  // Next-state for protection flags
  always_comb begin
    oc_d  = oc_q;
    od_d  = od_q;
    stb_d = stb_q;
    oi_d  = oi_q;
    xc_d  = xc_q;
    if (d_ocd) oc_d = 1'b1;
    if (d_ocr) oc_d = 1'b0;
    if (d_oid || d_scd) oi_d = 1'b1;
    if (d_oir) oi_d = 1'b0;
    // Overdischarge last, so it cancels a same-cycle over-current
    if (d_odd) begin
      od_d  = 1'b1;
      stb_d = 1'b1;
      oi_d  = 1'b0;
    end
    if (stb_q && stb_rel) stb_d = 1'b0;
    if (d_odr) od_d = 1'b0;
    if (d_xcd) xc_d = 1'b1;
    if (d_xcr) xc_d = 1'b0;
  end

  // Register protection flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oc_q  <= 1'b0;
      od_q  <= 1'b0;
      stb_q <= 1'b0;
      oi_q  <= 1'b0;
      xc_q  <= 1'b0;
    end else begin
      oc_q  <= oc_d;
      od_q  <= od_d;
      stb_q <= stb_d;
      oi_q  <= oi_d;
      xc_q  <= xc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate and resistor outputs, all from flags
  logic cg_q, cg_d;
  logic dg_q, dg_d;
  logic pu_q, pu_d;
  logic pd_q, pd_d;

  // Next gate and resistor levels from the next flag values
  always_comb begin
    cg_d = !(oc_d || xc_d);
    dg_d = !(od_d || oi_d);
    pu_d = od_d;
    pd_d = oi_d && !od_d;
  end

  // Register gate and resistor outputs, gates on after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cg_q <= 1'b1;
      dg_q <= 1'b1;
      pu_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      cg_q <= cg_d;
      dg_q <= dg_d;
      pu_q <= pu_d;
      pd_q <= pd_d;
    end
  end

  assign charge_gate              = cg_q;
  assign discharge_gate           = dg_q;
  assign pullup_resistor_enable   = pu_q;
  assign pulldown_resistor_enable = pd_q;
  assign standby                  = stb_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checker run lengths, kept apart from the delay timers
  tcp_pkg::tcp_cnt_t ocd_run_q, ocd_run_d;
  tcp_pkg::tcp_cnt_t odd_run_q, odd_run_d;
  tcp_pkg::tcp_cnt_t oid_run_q, oid_run_d;
  tcp_pkg::tcp_cnt_t scd_run_q, scd_run_d;

  // Consecutive cycles of each pending overcharge, overdischarge, over-current and short detection, saturating
  always_comb begin
    ocd_run_d = '0;
    odd_run_d = '0;
    oid_run_d = '0;
    scd_run_d = '0;
    if (c_ocd) ocd_run_d = (&ocd_run_q) ? ocd_run_q : ocd_run_q + 25'h0000001;
    if (c_odd) odd_run_d = (&odd_run_q) ? odd_run_q : odd_run_q + 25'h0000001;
    if (c_oid) oid_run_d = (&oid_run_q) ? oid_run_q : oid_run_q + 25'h0000001;
    if (c_scd) scd_run_d = (&scd_run_q) ? scd_run_q : scd_run_q + 25'h0000001;
  end

  // Register run lengths
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ocd_run_q <= '0;
      odd_run_q <= '0;
      oid_run_q <= '0;
      scd_run_q <= '0;
    end else begin
      ocd_run_q <= ocd_run_d;
      odd_run_q <= odd_run_d;
      oid_run_q <= oid_run_d;
      scd_run_q <= scd_run_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on flags, gates and resistors
  a_oc_gate_low: assert property (@(posedge clock) disable iff (!rst_n)
    oc_q |-> !charge_gate)
    else $error("charge gate high during overcharge");
  a_od_gate_low: assert property (@(posedge clock) disable iff (!rst_n)
    od_q |-> !discharge_gate)
    else $error("discharge gate high in overdischarge");
  a_od_standby: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(od_q) |-> stb_q)
    else $error("no standby after overdischarge");
  a_od_pullup: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(od_q) |=> pullup_resistor_enable)
    else $error("pull-up not enabled");
  a_stb_hold: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(stb_q) |-> $past(stb_rel))
    else $error("standby left without release");
  a_oi_pulldown: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(oi_q) |=> pulldown_resistor_enable || od_q)
    else $error("pull-down missing");
  a_pd_oi: assert property (@(posedge clock) disable iff (!rst_n)
    pulldown_resistor_enable |-> oi_q)
    else $error("pull-down on without over-current");
  a_oi_nostb: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(oi_q) |-> !$rose(stb_q))
    else $error("standby after over-current");
  a_oc_noci: assert property (@(posedge clock) disable iff (!rst_n)
    oc_q |-> !c_oid)
    else $error("over-current counted in overcharge");
  a_xc_hold: assert property (@(posedge clock) disable iff (!rst_n)
    od_q |-> !c_xcd)
    else $error("excess charger counted in overdischarge");
  a_sc_fixed: assert property (@(posedge clock) disable iff (!rst_n)
    l_scd == 25'h0001388)
    else $error("short delay not 0.25 ms");
  a_sc_shorter: assert property (@(posedge clock) disable iff (!rst_n)
    !tst |-> (l_scd < l_oid))
    else $error("short delay not below over-current delay");

  // Timing checks against the independent run lengths, then release-condition checks
  a_oc_det_time: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(oc_q) |-> (ocd_run_q >= l_ocd))
    else $error("overcharge confirmed early");
  a_od_det_time: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(od_q) |-> (odd_run_q >= l_odd))
    else $error("overdischarge confirmed early");
  a_oi_det_time: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(oi_q) |-> (oid_run_q >= l_oid) || (scd_run_q >= l_scd))
    else $error("over-current or short confirmed early");
  a_oc_release: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(oc_q) |-> $past(oc_rel && (!node_hi || load_on)))
    else $error("overcharge released without release level");
  a_od_release: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(od_q) |-> $past(od_rel && !stb_q))
    else $error("overdischarge released in standby or low cell");
endmodule

// ===== tcp_defs.svh
// Constants for the two-cell protection control logic
// Assumes a 20 MHz internal clock (50 ns period)
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH

// Clock rate in Hz
`define TCP_CLK_HZ          20000000
// Delay figures, in microseconds
`define TCP_OC_DET_US       1000000
`define TCP_OC_REL_US       40000
`define TCP_OD_DET_US       100000
`define TCP_OD_REL_US       1000
`define TCP_OI_DET_US       20000
`define TCP_OI_REL_US       1000
`define TCP_SC_DET_US       250
`define TCP_XC_DET_US       1500
`define TCP_XC_REL_US       1500
// Cycle counts derived from the figures
`define TCP_US2CYC(us)      ((us) * (`TCP_CLK_HZ / 1000000))
// Shortening divide factor in test mode
`define TCP_TEST_DIV        1000
// Counter width
`define TCP_CNT_W           25

`endif

// ===== tcp_pkg.sv
// Types for the two-cell protection control logic
// Assumes tcp_defs.svh supplies the numeric constants
package tcp_pkg;
  typedef logic [24:0] tcp_cnt_t;
endpackage

// ===== tcp_delay.sv
// Qualifying delay timer: output rises once input held for limit cycles
// Assumes input synchronous to clock; limit stable while counting
`timescale 1ns/1ps
`include "tcp_defs.svh"

module tcp_delay (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst_n,
  // Condition and limit
  input  wire logic          cond,
  input  wire tcp_pkg::tcp_cnt_t limit,
  // Qualified result
  output logic               done
);
  tcp_pkg::tcp_cnt_t cnt_q;
  tcp_pkg::tcp_cnt_t cnt_d;
  logic              done_q;
  logic              done_d;

  // Count while condition holds, restart when it drops
  always_comb begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (!cond) begin
      cnt_d = '0;
    end else if (cnt_q >= limit - 25'h0000001) begin
      done_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 25'h0000001;
    end
  end

  // Register counter state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  // Gated by the condition so a condition lost in the last cycle never fires
  assign done = done_q & cond;
endmodule

// ===== tcp_far_side.sv
// Far-side model: load, charger and the charger-negative node
// Assumes bench commands change at the falling clock edge
`timescale 1ns/1ps

module tcp_far_side (
  // Device controls
  input  wire logic discharge_gate,
  input  wire logic pullup_resistor_enable,
  // Bench commands
  input  wire logic heavy_load,
  input  wire logic charger_on,
  input  wire logic charger_hot,
  // Comparator levels seen by the device
  output logic      load_node_above_oc,
  output logic      load_present,
  output logic      excess_charger_det,
  output logic      standby_release
);
  // Node held high by a load, or by the pull-up with no charger attached
  assign load_node_above_oc = heavy_load | (pullup_resistor_enable & ~charger_on);
  assign load_present       = heavy_load;
  // Charger drags the node low; hidden while the discharge FET is off
  assign excess_charger_det = charger_on & charger_hot & discharge_gate;
  assign standby_release    = charger_on;
endmodule

// ===== tb_top.sv
// Self-checking bench for the protection control logic
// Assumes tcp_defs.svh constants; runs mostly in shortening mode
`timescale 1ns/1ps
`include "tcp_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end

module tb_top;
  localparam int DIV    = `TCP_TEST_DIV;
  localparam int OC_DET = `TCP_US2CYC(`TCP_OC_DET_US) / DIV;
  localparam int OC_REL = `TCP_US2CYC(`TCP_OC_REL_US) / DIV;
  localparam int OD_DET = `TCP_US2CYC(`TCP_OD_DET_US) / DIV;
  localparam int OD_REL = `TCP_US2CYC(`TCP_OD_REL_US) / DIV;
  localparam int OI_DET = `TCP_US2CYC(`TCP_OI_DET_US) / DIV;
  localparam int OI_REL = `TCP_US2CYC(`TCP_OI_REL_US) / DIV;
  localparam int SC_DET = `TCP_US2CYC(`TCP_SC_DET_US);
  localparam int XC_DET = `TCP_US2CYC(`TCP_XC_DET_US) / DIV;
  localparam int XC_REL = `TCP_US2CYC(`TCP_XC_REL_US) / DIV;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        ovc_det = 1'b0, ovc_ok = 1'b1, ovd_det = 1'b0, ovd_ok = 1'b1;
  logic        short_det = 1'b0, test_shorten = 1'b1;
  logic        heavy = 1'b0, chg_on = 1'b0, chg_hot = 1'b0;
  logic        above_oc, present, xc_det, stb_rel;
  logic        cg, dg, pu, pd, stb;
  logic [4:0]  outs, exp_o;
  logic [31:0] lfsr = 32'h69B6;
  int          miscompares = 0;
  int          n_compared = 0;

  ////////////////////////////////////////////////////////////////////////
  // Clock and design under test
  always #25 clock = ~clock;
  assign outs = {cg, dg, pu, pd, stb};
  tcp_fsm u_tcp_fsm (.clock(clock), .rst_n(rst_n), .overcharge_det(ovc_det),
    .overcharge_rel_ok(ovc_ok), .overdischarge_det(ovd_det), .overdischarge_rel_ok(ovd_ok),
    .load_node_above_oc(above_oc), .load_present(present), .short_det(short_det),
    .excess_charger_det(xc_det), .standby_release(stb_rel), .test_shorten(test_shorten),
    .charge_gate(cg), .discharge_gate(dg), .pullup_resistor_enable(pu),
    .pulldown_resistor_enable(pd), .standby(stb));
  tcp_far_side u_tcp_far_side (.discharge_gate(dg), .pullup_resistor_enable(pu),
    .heavy_load(heavy), .charger_on(chg_on), .charger_hot(chg_hot),
    .load_node_above_oc(above_oc), .load_present(present), .excess_charger_det(xc_det),
    .standby_release(stb_rel));

  ////////////////////////////////////////////////////////////////////////
  // Bench tasks
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  task automatic test_done();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Device outputs checked after n cycles, then must take the next value within 10 cycles
  task automatic settle(input int n, input logic [4:0] nxt);
    int k;
    repeat (n) @(posedge clock);
    #1;
    `CHK(outs, exp_o)
    k = 0;
    while (outs !== nxt && k < 10) begin
      @(posedge clock);
      #1;
      k++;
    end
    exp_o = nxt;
    `CHK(outs, exp_o)
    @(negedge clock);
  endtask

  task automatic do_reset(input string name);
    if (name != "") begin
      $display("test %s done", name);
    end
    @(negedge clock);
    {ovc_det, ovd_det, short_det, heavy, chg_on, chg_hot} = 6'h00;
    {ovc_ok, ovd_ok, test_shorten} = 3'h7;
    rst_n = 1'b0;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    exp_o = 5'h18;
    settle(2, 5'h18);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    do_reset("");
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      heavy = 1'b1;
      repeat (20 + int'(lfsr[7:0])) @(negedge clock);
      heavy = 1'b0;
      settle(OI_DET, 5'h18);
    end
    heavy = 1'b1;
    settle(OI_DET, 5'h12);
    heavy = 1'b0;
    settle(OI_REL, 5'h18);
    test_shorten = 1'b0;
    heavy = 1'b1;
    settle(OI_DET * 3, 5'h18);
    heavy = 1'b0;
    short_det = 1'b1;
    settle(SC_DET, 5'h12);
    do_reset("overcurrent");
    short_det = 1'b1;
    settle(SC_DET, 5'h12);
    do_reset("short");
    ovc_det = 1'b1;
    ovc_ok = 1'b0;
    settle(OC_DET, 5'h08);
    ovc_det = 1'b0;
    heavy = 1'b1;
    settle(OC_REL + OI_DET + 20, 5'h08);
    ovc_ok = 1'b1;
    settle(OC_REL, 5'h18);
    heavy = 1'b0;
    chg_on = 1'b1;
    chg_hot = 1'b1;
    settle(XC_DET, 5'h08);
    chg_hot = 1'b0;
    settle(XC_REL, 5'h18);
    do_reset("overcharge");
    ovd_det = 1'b1;
    ovd_ok = 1'b0;
    settle(OD_DET, 5'h15);
    chg_on = 1'b1;
    chg_hot = 1'b1;
    settle(0, 5'h14);
    ovd_det = 1'b0;
    ovd_ok = 1'b1;
    settle(OD_REL, 5'h18);
    settle(XC_DET, 5'h08);
    do_reset("overdischarge");
    test_done();
  end

  // Watchdog against a hung scenario
  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    test_done();
  end
endmodule
